// file: psc_status_irq.sv
// Status and host interrupt enable registers with the host interrupt pin
// Operation
// RULE1 - Status set writes set software status bits
// RULE2 - Status set writes set error status bits
// RULE3 - Status clear writes clear software status bits
// RULE4 - Status clear writes clear error status bits
// RULE5 - Software always writes zero to bit 31
// RULE6 - Pin low when masked status in D0
// RULE7 - Pin released in D1, D2, D3
// RULE8 - Enable set writes set enable bits
// RULE9 - Enable clear writes clear enable bits
// RULE10 - Enable set read returns enable register
// RULE11 - Enable clear read returns status AND enable
// RULE12 - Host reads enable clear to find source
// RULE13 - Enable fields reset zero, others read zero
// RULE14 - Host reaches registers through address windows
// RULE15 - Clear ignored while setting condition persists
// RULE16 - Status port reads return status register
// RULE17 - Cleared condition seen three clocks later
// RULE18 - Reserved bits ignored, read as zero
// RULE19 - Hardware set wins over software clear
`timescale 1ns/1ns
`default_nettype none
`include "psc_regs.svh"

module psc_status_irq (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic I_PCI_CLK,
  input wire logic I_PCI_PARITY_ERROR_SEEN,
  input wire logic I_PCI_SYSTEM_ERROR_SEEN,
  input wire logic I_PCI_MASTER_ABORT_SEEN,
  input wire logic I_PCI_TARGET_ABORT_SEEN,
  input wire logic [1:0] I_PCI_PWR_STATE,
  input wire logic I_REG_SEL,
  input wire logic I_REG_WR,
  input wire logic [1:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  output logic [31:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  output logic O_HOST_IRQ_PIN_N_O,
  output logic O_HOST_IRQ_PIN_N_OE_N
);

  // ------------------------------------------------------------------
  // PCI clock domain: condition and power state capture
  // ------------------------------------------------------------------
  psc_pkg::psc_link_s link_reg;
  psc_pkg::psc_link_s link_next;

  // The power state is reduced to one level here so that only single-bit
  // levels cross, which a plain synchroniser carries safely
  always_comb begin
    link_next = link_reg;
    link_next.cond = {I_PCI_PARITY_ERROR_SEEN, I_PCI_SYSTEM_ERROR_SEEN,
                      I_PCI_MASTER_ABORT_SEEN, I_PCI_TARGET_ABORT_SEEN};
    link_next.in_d0 = (I_PCI_PWR_STATE == `PSC_PWR_D0);
  end

  always_ff @(posedge I_PCI_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // ------------------------------------------------------------------
  // Crossing into the peripheral clock domain
  // ------------------------------------------------------------------
  psc_sync_if sif ();

  assign sif.src_lvl = {link_reg.in_d0, link_reg.cond};

  psc_sync u_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .sif(sif)
  );

  // ------------------------------------------------------------------
  // Peripheral clock domain
  // ------------------------------------------------------------------
  psc_pkg::psc_core_s core_reg;
  psc_pkg::psc_core_s core_next;

  logic [4:0] lvl_agree;
  logic [4:0] lvl_now;
  logic [3:0] hw_cond;
  logic in_d0;
  psc_pkg::psc_word_t hw_word;
  psc_pkg::psc_word_t wmask;
  psc_pkg::psc_word_t stat_set;
  psc_pkg::psc_word_t stat_clr;
  psc_pkg::psc_word_t en_set;
  psc_pkg::psc_word_t en_clr;
  psc_pkg::psc_word_t status_upd;
  psc_pkg::psc_word_t enable_upd;
  psc_pkg::psc_word_t masked;
  psc_pkg::psc_port_e port;
  logic wr_en;
  logic rd_en;

  // A level change counts once the second and third stages agree;
  // otherwise the last agreed value is held
  always_comb begin
    lvl_agree = ~(sif.ff2_lvl ^ sif.ff3_lvl);
    lvl_now = (lvl_agree & sif.ff3_lvl) | (~lvl_agree & core_reg.lvl_held); // RULE17
  end

  assign hw_cond = lvl_now[3:0];
  assign in_d0 = lvl_now[4];

  // Place the four condition levels at their status bit positions
  always_comb begin
    hw_word = '0;
    hw_word[`PSC_BIT_PARITY] = hw_cond[3];
    hw_word[`PSC_BIT_SYSTEM] = hw_cond[2];
    hw_word[`PSC_BIT_MASTER_ABORT] = hw_cond[1];
    hw_word[`PSC_BIT_TARGET_ABORT] = hw_cond[0];
  end

  // Bus decode
  assign port = psc_pkg::psc_port_e'(I_REG_ADDR);
  assign wr_en = I_REG_SEL & I_REG_WR;
  assign rd_en = I_REG_SEL & ~I_REG_WR;

  // Bit 31 and every other reserved position are dropped from writes
  assign wmask = `PSC_IMPL_MASK; // RULE18 RULE5

  always_comb begin
    stat_set = '0;
    stat_clr = '0;
    en_set = '0;
    en_clr = '0;
    if (wr_en && port == psc_pkg::PSC_PORT_STATUS_SET) begin
      stat_set = I_REG_WDATA & wmask; // RULE1 RULE2
    end else if (wr_en && port == psc_pkg::PSC_PORT_STATUS_CLEAR) begin
      stat_clr = I_REG_WDATA & wmask; // RULE3 RULE4
    end else if (wr_en && port == psc_pkg::PSC_PORT_ENABLE_SET) begin
      en_set = I_REG_WDATA & wmask; // RULE8
    end else if (wr_en && port == psc_pkg::PSC_PORT_ENABLE_CLEAR) begin
      en_clr = I_REG_WDATA & wmask; // RULE9
    end
  end

  // Status update: set sources win, and a clear cannot remove a bit whose
  // condition is still present, so no detected event is lost
  always_comb begin
    status_upd = core_reg.status & ~(stat_clr & ~hw_word); // RULE15
    status_upd = status_upd | stat_set | hw_word; // RULE19
    status_upd = status_upd & `PSC_IMPL_MASK; // RULE18
  end

  // The enable register has no direct write path; only set and clear
  always_comb begin
    enable_upd = (core_reg.enable | en_set) & ~en_clr;
    enable_upd = enable_upd & `PSC_IMPL_MASK; // RULE13
  end

  assign masked = core_reg.status & core_reg.enable;

  always_comb begin
    core_next = core_reg;
    core_next.lvl_held = lvl_now;
    core_next.status = status_upd;
    core_next.enable = enable_upd;
    core_next.rvalid = rd_en;
    if (rd_en && port == psc_pkg::PSC_PORT_STATUS_SET) begin
      core_next.rdata = core_reg.status; // RULE16
    end else if (rd_en && port == psc_pkg::PSC_PORT_STATUS_CLEAR) begin
      core_next.rdata = core_reg.status; // RULE16
    end else if (rd_en && port == psc_pkg::PSC_PORT_ENABLE_SET) begin
      core_next.rdata = core_reg.enable; // RULE10
    end else if (rd_en && port == psc_pkg::PSC_PORT_ENABLE_CLEAR) begin
      core_next.rdata = masked; // RULE11 RULE12
    end
    // Level interrupt only in D0; released in any lower power state
    core_next.irq_drive = (|masked) & in_d0; // RULE6 RULE7
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      core_reg.status <= `PSC_STATUS_RESET;
      core_reg.enable <= `PSC_ENABLE_RESET; // RULE13
      core_reg.rdata <= '0;
      core_reg.rvalid <= 1'b0;
      core_reg.irq_drive <= 1'b0;
      core_reg.lvl_held <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  // Register window seen by the local processor and, through the address
  // windows, by the external host
  assign O_REG_RDATA = core_reg.rdata; // RULE14
  assign O_REG_RVALID = core_reg.rvalid;

  // Open-drain pin: drive low while asserted, otherwise released
  assign O_HOST_IRQ_PIN_N_O = 1'b0;
  assign O_HOST_IRQ_PIN_N_OE_N = ~core_reg.irq_drive; // RULE6

endmodule // psc_status_irq

`default_nettype wire

// file: psc_regs.svh
// Register indices, field positions, reset values and timing counts of the status/enable block
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

`define PSC_IDX_STATUS_SET 2'h0
`define PSC_IDX_STATUS_CLEAR 2'h1
`define PSC_IDX_ENABLE_SET 2'h2
`define PSC_IDX_ENABLE_CLEAR 2'h3

`define PSC_BIT_SOFT_LSB 24
`define PSC_BIT_SOFT_MSB 27
`define PSC_BIT_PARITY 6
`define PSC_BIT_SYSTEM 5
`define PSC_BIT_MASTER_ABORT 2
`define PSC_BIT_TARGET_ABORT 1
`define PSC_BIT_WRITE_ZERO 31

`define PSC_SOFT_MASK 32'h0f00_0000
`define PSC_ERR_MASK 32'h0000_0066
`define PSC_IMPL_MASK 32'h0f00_0066

`define PSC_STATUS_RESET 32'h0000_0000
`define PSC_ENABLE_RESET 32'h0000_0000

`define PSC_PWR_D0 2'h0
`define PSC_COND_WIDTH 4
`define PSC_SYNC_WIDTH 5
`define PSC_SYNC_CYCLES 3

`endif

// file: psc_pkg.sv
// Types shared by the status/enable block
package psc_pkg;

  typedef logic [31:0] psc_word_t;

  typedef enum logic [1:0] {
    PSC_PORT_STATUS_SET,
    PSC_PORT_STATUS_CLEAR,
    PSC_PORT_ENABLE_SET,
    PSC_PORT_ENABLE_CLEAR
  } psc_port_e;

  // Peripheral clock domain state
  typedef struct packed {
    psc_word_t status;
    psc_word_t enable;
    psc_word_t rdata;
    logic rvalid;
    logic irq_drive;
    logic [4:0] lvl_held;
  } psc_core_s;

  // PCI clock domain capture state
  typedef struct packed {
    logic [3:0] cond;
    logic in_d0;
  } psc_link_s;

  // Synchroniser state
  typedef struct packed {
    logic [4:0] ff1;
    logic [4:0] ff2;
    logic [4:0] ff3;
  } psc_sync_s;

endpackage

// file: psc_sync_if.sv
// Carrier for levels passed from the PCI clock domain into the peripheral clock domain
`timescale 1ns/1ns
`default_nettype none

interface psc_sync_if;
  logic [4:0] src_lvl;
  logic [4:0] ff2_lvl;
  logic [4:0] ff3_lvl;

  modport src (output src_lvl);
  modport sync (input src_lvl, output ff2_lvl, output ff3_lvl);
  modport dst (input ff2_lvl, input ff3_lvl);
endinterface

`default_nettype wire

// file: psc_sync.sv
// Three-stage level synchroniser into the peripheral clock domain
`timescale 1ns/1ns
`default_nettype none

module psc_sync (
  input wire logic i_clk,
  input wire logic i_rst_b,
  psc_sync_if.sync sif
);

  psc_pkg::psc_sync_s state_reg;
  psc_pkg::psc_sync_s state_next;

  // The first stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.ff1 = sif.src_lvl;
    state_next.ff2 = state_reg.ff1;
    state_next.ff3 = state_reg.ff2;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sif.ff2_lvl = state_reg.ff2;
  assign sif.ff3_lvl = state_reg.ff3;

endmodule // psc_sync

`default_nettype wire

// file: psc_pci_model.sv
// PCI-side source of error conditions and power state
`timescale 1ns/1ns
`default_nettype none
module psc_pci_model (
  input wire logic i_pci_clk,
  input wire logic [3:0] i_cond_req,
  input wire logic [1:0] i_pwr_req,
  output logic [3:0] o_cond,
  output logic [1:0] o_pwr
);
  initial {o_cond, o_pwr} = 6'h00;
  // Levels move only just after a link edge, as a real PCI-side source would
  always @(posedge i_pci_clk) {o_cond, o_pwr} <= {i_cond_req, i_pwr_req};
endmodule // psc_pci_model
`default_nettype wire

// file: psc_status_irq_sva.sv
// Concurrent checks on the ports of the status and host interrupt block
`timescale 1ns/1ns
`default_nettype none
module psc_status_irq_sva (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic [1:0] I_PCI_PWR_STATE,
  input wire logic I_REG_SEL,
  input wire logic I_REG_WR,
  input wire logic [1:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic [31:0] O_REG_RDATA,
  input wire logic O_REG_RVALID,
  input wire logic O_HOST_IRQ_PIN_N_OE_N
);
  localparam logic [31:0] impl = 32'h0f00_0066;
  logic [3:0] low_pwr_reg;
  wire logic rd = I_REG_SEL && !I_REG_WR;
  wire logic wr = I_REG_SEL && I_REG_WR;
  // Low power must outlast link capture and synchroniser before the pin is judged
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) low_pwr_reg <= 4'h0;
    else if (I_PCI_PWR_STATE == 2'h0) low_pwr_reg <= 4'h0;
    else if (low_pwr_reg != 4'hf) low_pwr_reg <= low_pwr_reg + 4'h1;
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  a_read_answer: assert property (rd |=> O_REG_RVALID)
    else $error("read got no answer");
  a_answer_cause: assert property (O_REG_RVALID |-> $past(rd))
    else $error("answer without read");
  a_reserved_zero: assert property (O_REG_RVALID |-> (O_REG_RDATA & ~impl) == 32'h0)
    else $error("reserved bits read nonzero");
  a_low_pwr_pin: assert property (low_pwr_reg == 4'hf |-> O_HOST_IRQ_PIN_N_OE_N)
    else $error("pin asserted outside D0");
  a_en_set_seen: assert property (rd && I_REG_ADDR == 2'h2 && $past(wr && I_REG_ADDR == 2'h2)
    |=> (O_REG_RDATA & $past(I_REG_WDATA, 2) & impl) == ($past(I_REG_WDATA, 2) & impl))
    else $error("enable set not seen");
  a_en_clr_seen: assert property (rd && I_REG_ADDR == 2'h2 && $past(wr && I_REG_ADDR == 2'h3)
    |=> (O_REG_RDATA & $past(I_REG_WDATA, 2)) == 32'h0)
    else $error("enable clear not seen");
  a_st_set_seen: assert property (rd && I_REG_ADDR == 2'h0 && $past(wr && I_REG_ADDR == 2'h0)
    |=> (O_REG_RDATA & $past(I_REG_WDATA, 2) & impl) == ($past(I_REG_WDATA, 2) & impl))
    else $error("status set not seen");
  a_st_clr_seen: assert property (rd && I_REG_ADDR == 2'h1 && $past(wr && I_REG_ADDR == 2'h1)
    |=> (O_REG_RDATA & $past(I_REG_WDATA, 2) & 32'h0f00_0000) == 32'h0)
    else $error("status clear not seen");
  c_read: cover property (rd ##1 O_REG_RVALID);
  c_pin: cover property ($fell(O_HOST_IRQ_PIN_N_OE_N));
  c_low_pwr: cover property (low_pwr_reg == 4'hf);
endmodule // psc_status_irq_sva
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the status and host interrupt block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0, pci_clk = 1'b0, rst_b = 1'b0, sel = 1'b0, wr = 1'b0;
  logic [1:0] addr = 2'h0, pwr_req = 2'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] cond_req = 4'h0;
  wire logic [3:0] cond;
  wire logic [1:0] pwr;
  wire logic [31:0] rdata;
  wire logic rvalid, pin_o, oe_n;
  int n_fail = 0, tests_run = 0;
  always #5 clk = ~clk;
  // Link clock offset by 1 ns so its rising edges never share a time step
  // with the falling edge on which the bench moves the condition requests
  initial begin
    #1;
    forever #24 pci_clk = ~pci_clk;
  end
  psc_pci_model PCI (.i_pci_clk(pci_clk), .i_cond_req(cond_req), .i_pwr_req(pwr_req),
    .o_cond(cond), .o_pwr(pwr));
  psc_status_irq DUT (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_PCI_CLK(pci_clk),
    .I_PCI_PARITY_ERROR_SEEN(cond[3]), .I_PCI_SYSTEM_ERROR_SEEN(cond[2]),
    .I_PCI_MASTER_ABORT_SEEN(cond[1]), .I_PCI_TARGET_ABORT_SEEN(cond[0]),
    .I_PCI_PWR_STATE(pwr), .I_REG_SEL(sel), .I_REG_WR(wr), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
    .O_HOST_IRQ_PIN_N_O(pin_o), .O_HOST_IRQ_PIN_N_OE_N(oe_n));
  task automatic tally_and_finish();
    $display("Counts: run %0d fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Host access through its window; bit 31 of every write stays zero
  task automatic op(input logic w, input logic [1:0] a, input logic [31:0] d);
    sel = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    op(1'b0, a, 32'h0);
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask
  task automatic idle(input int n);
    sel = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task automatic s_reset();
    for (int a = 0; a < 4; a++) rd(2'(a), 32'h0);
    chk({31'h0, oe_n}, 32'h1);
    chk({31'h0, pin_o}, 32'h0);
  endtask
  task automatic s_status();
    op(1'b1, 2'h0, 32'h7fff_ffff);
    rd(2'h0, 32'h0f00_0066);
    op(1'b1, 2'h1, 32'h0500_0024);
    rd(2'h1, 32'h0a00_0042);
    chk({31'h0, oe_n}, 32'h1);
  endtask
  task automatic s_enable();
    op(1'b1, 2'h2, 32'h7fff_ffff);
    rd(2'h2, 32'h0f00_0066);
    op(1'b1, 2'h3, 32'h0300_0060);
    rd(2'h2, 32'h0c00_0006);
    rd(2'h3, 32'h0800_0002);
    chk({31'h0, oe_n}, 32'h0);
    op(1'b1, 2'h3, 32'h0800_0002);
    idle(2);
    chk({31'h0, oe_n}, 32'h1);
  endtask
  task automatic s_pwr();
    op(1'b1, 2'h2, 32'h0800_0000);
    for (int p = 1; p < 4; p++) begin
      pwr_req = 2'(p);
      idle(20);
      chk({31'h0, oe_n}, 32'h1);
      pwr_req = 2'h0;
      idle(20);
      chk({31'h0, oe_n}, 32'h0);
    end
  endtask
  task automatic s_hw();
    int b[4] = '{1, 2, 5, 6};
    op(1'b1, 2'h1, 32'h0f00_0066);
    for (int i = 0; i < 4; i++) begin
      cond_req = 4'(1 << i);
      idle(20);
      rd(2'h0, 32'h1 << b[i]);
      op(1'b1, 2'h1, 32'h1 << b[i]);
      rd(2'h1, 32'h1 << b[i]);
      cond_req = 4'h0;
      idle(20);
      op(1'b1, 2'h1, 32'h1 << b[i]);
      rd(2'h1, 32'h0);
    end
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    s_reset();
    s_status();
    s_enable();
    s_pwr();
    s_hw();
    idle(2);
    tally_and_finish();
  end
  // About thirty times the expected run
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
endmodule // testbench
bind psc_status_irq psc_status_irq_sva u_sva (.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B),
  .I_PCI_PWR_STATE(I_PCI_PWR_STATE), .I_REG_SEL(I_REG_SEL), .I_REG_WR(I_REG_WR),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
  .O_REG_RVALID(O_REG_RVALID), .O_HOST_IRQ_PIN_N_OE_N(O_HOST_IRQ_PIN_N_OE_N));
`default_nettype wire
